// *** pkg/brto_pkg.sv ***
// constants, types and step functions of the boundary run-test operations
package brto_pkg;

  // ==========================================================================
  // cell geometry
  localparam int IO_W        = 40;
  localparam int HALF_W      = 20;
  localparam int CTRL_W      = 12;
  localparam int CTRL_HI_POS = 47;
  localparam int CTRL_LO_POS = 36;
  localparam int OE_A_POS    = 47;
  localparam int OE_B_POS    = 46;
  localparam int OE_A_IDX    = OE_A_POS - CTRL_LO_POS;
  localparam int OE_B_IDX    = OE_B_POS - CTRL_LO_POS;
  localparam int OP_LSB      = 0;
  localparam int OP_W        = 3;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // reset values
  localparam logic [IO_W-1:0]   IO_RESET     = 40'h00_0000_0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 12'hFFF;
  localparam logic [IO_W-1:0]   SHADOW_RESET = 40'h00_0000_0000;

  // ==========================================================================
  // feedback taps: x^40+x^38+x^21+x^19+1 and x^20+x^17+1
  localparam logic [IO_W-1:0]   TAPS40 = 40'hA0_0014_0000;
  localparam logic [HALF_W-1:0] TAPS20 = 20'h9_0000;

  // ==========================================================================
  // operations
  typedef enum logic [2:0] {
    OP_TOGGLE,
    OP_RANDOM,
    OP_SIG,
    OP_SIG_RANDOM,
    OP_SIG_COUNT
  } brto_op_t;

  function automatic brto_op_t brtoDecode(input logic [OP_W-1:0] code);
    if (code[1:0] == 2'h0) return OP_TOGGLE;
    else if (code[1:0] == 2'h1) return OP_RANDOM;
    else if (code[1:0] == 2'h2) return OP_SIG;
    else if (code[2]) return OP_SIG_COUNT;
    else return OP_SIG_RANDOM;
  endfunction : brtoDecode

  // fibonacci step; reversed order for the other flow direction
  function automatic logic [IO_W-1:0] brtoStep40(input logic [IO_W-1:0] v, input logic rev);
    logic [IO_W-1:0] w;
    w = v;
    if (rev) begin
      w = {<<{v}};
    end
    w = {w[IO_W-2:0], ^(w & TAPS40)};
    if (rev) begin
      w = {<<{w}};
    end
    return w;
  endfunction : brtoStep40

  function automatic logic [HALF_W-1:0] brtoStep20(input logic [HALF_W-1:0] v,
                                                   input logic rev);
    logic [HALF_W-1:0] w;
    w = v;
    if (rev) begin
      w = {<<{v}};
    end
    w = {w[HALF_W-2:0], ^(w & TAPS20)};
    if (rev) begin
      w = {<<{w}};
    end
    return w;
  endfunction : brtoStep20

endpackage : brto_pkg

// *** pkg/brto_tck_if.sv ***
// carrier for the sampled test clock edges
`timescale 1ns/1ps
interface brto_tck_if;
  logic rise;
  logic fall;
  modport source (output rise, output fall);
  modport sink   (input rise, input fall);
endinterface : brto_tck_if

// *** src/brto_sync.sv ***
// two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module brto_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule : brto_sync

// *** src/brto_tck_edge.sv ***
// samples the test clock and flags its rising and falling edges
`timescale 1ns/1ps
module brto_tck_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // test clock pin
  input  wire logic tck,
  // edges
  brto_tck_if.source edges
);

  logic tckS1_reg;
  logic tckS2_reg;
  logic tckS3_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tckS1_reg <= 1'b0;
      tckS2_reg <= 1'b0;
      tckS3_reg <= 1'b0;
    end else begin
      tckS1_reg <= tck;
      tckS2_reg <= tckS1_reg;
      tckS3_reg <= tckS2_reg;
    end
  end

  assign edges.rise = tckS2_reg & ~tckS3_reg;
  assign edges.fall = ~tckS2_reg & tckS3_reg;

endmodule : brto_tck_edge

// *** src/brto_run_test.sv ***
// built-in test operations on the I/O boundary cells during run-test idle
`timescale 1ns/1ps
module brto_run_test (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // test access
  input  wire logic                         tck,
  input  wire logic                         tapIdle,
  input  wire logic                         runTestInstr,
  input  wire logic [brto_pkg::OP_W-1:0]    boundaryControlOp,
  // flow enables, active low
  input  wire logic                         oeAtoBn,
  input  wire logic                         oeBtoAn,
  // pins, A at 19..0 and B at 39..20
  input  wire logic [brto_pkg::IO_W-1:0]    pinIn,
  output logic      [brto_pkg::IO_W-1:0]    pinOut,
  output logic      [brto_pkg::IO_W-1:0]    pinOe,
  // scan load from the shift path
  input  wire logic                         scanLoad,
  input  wire logic [brto_pkg::IO_W-1:0]    scanIoData,
  input  wire logic [brto_pkg::CTRL_W-1:0]  scanCtrlData,
  // cell contents and status
  output logic      [brto_pkg::IO_W-1:0]    ioCells,
  output logic      [brto_pkg::CTRL_W-1:0]  ctrlCells,
  output logic                              opActive
);

  localparam int IW = brto_pkg::IO_W;
  localparam int HW = brto_pkg::HALF_W;
  localparam int CW = brto_pkg::CTRL_W;
  localparam int SW = brto_pkg::OP_W + 4 + IW;

  // ==========================================================================
  // input synchronisation
  logic [SW-1:0]            syncIn;
  logic [SW-1:0]            syncOut;
  logic [brto_pkg::OP_W-1:0] bcrS;
  logic                     idleS;
  logic                     instrS;
  logic                     oeAbS;
  logic                     oeBaS;
  logic [IW-1:0]            pinS;

  assign syncIn = {boundaryControlOp, tapIdle, runTestInstr, oeAtoBn, oeBtoAn, pinIn};

  brto_sync #(.W(SW)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (syncIn),
    .dout (syncOut)
  );

  assign {bcrS, idleS, instrS, oeAbS, oeBaS, pinS} = syncOut;

  brto_tck_if tckIf ();

  brto_tck_edge u_edge (
    .clk   (clk),
    .rst   (rst),
    .tck   (tck),
    .edges (tckIf.source)
  );

  // ==========================================================================
  // state
  logic [IW-1:0] ioCells_reg;
  logic [IW-1:0] ioCells_next;
  logic [CW-1:0] ctrlCells_reg;
  logic [CW-1:0] ctrlCells_next;
  logic [IW-1:0] shadow_reg;
  logic [IW-1:0] shadow_next;
  logic [IW-1:0] pinOut_reg;
  logic [IW-1:0] pinOut_next;
  logic [IW-1:0] pinOe_reg;
  logic [IW-1:0] pinOe_next;
  logic          opActive_reg;
  logic          opActive_next;

  // ==========================================================================
  // decode
  brto_pkg::brto_op_t opSel;
  logic               runOp;
  logic               dirAtoB;
  logic               rev;
  logic [IW-1:0]      outMask;
  logic [HW-1:0]      inGroup;
  logic [HW-1:0]      outGroup;
  logic [HW-1:0]      inPins;
  logic [HW-1:0]      sig20;
  logic [HW-1:0]      out20;

  assign opSel   = brto_pkg::brtoDecode(bcrS);
  assign runOp   = instrS & idleS & (oeAbS != oeBaS);
  assign dirAtoB = ~oeAbS;
  assign rev     = ~dirAtoB;
  // enable cell low means output mode
  assign outMask = {{HW{~ctrlCells_reg[brto_pkg::OE_B_IDX]}},
                    {HW{~ctrlCells_reg[brto_pkg::OE_A_IDX]}}};
  assign inGroup  = dirAtoB ? ioCells_reg[HW-1:0] : ioCells_reg[IW-1:HW];
  assign outGroup = dirAtoB ? ioCells_reg[IW-1:HW] : ioCells_reg[HW-1:0];
  assign inPins   = dirAtoB ? pinS[HW-1:0] : pinS[IW-1:HW];
  assign sig20    = brto_pkg::brtoStep20(inGroup, rev) ^ inPins;
  assign out20    = (opSel == brto_pkg::OP_SIG_COUNT) ? outGroup + 20'h0_0001
                                                      : brto_pkg::brtoStep20(outGroup, rev);

  // ==========================================================================
  // next state
  always_comb begin
    ioCells_next   = ioCells_reg;
    ctrlCells_next = ctrlCells_reg;
    shadow_next    = shadow_reg;
    if (scanLoad) begin
      ioCells_next   = scanIoData;
      ctrlCells_next = scanCtrlData;
    end else if (runOp && tckIf.rise) begin
      case (opSel)
        brto_pkg::OP_TOGGLE: begin
          ioCells_next = (~ioCells_reg & outMask) | (pinS & ~outMask);
        end
        brto_pkg::OP_RANDOM: begin
          ioCells_next = brto_pkg::brtoStep40(ioCells_reg, rev);
        end
        brto_pkg::OP_SIG: begin
          ioCells_next = brto_pkg::brtoStep40(ioCells_reg, rev) ^ (pinS & ~outMask);
        end
        default: begin
          ioCells_next = dirAtoB ? {out20, sig20} : {sig20, out20};
        end
      endcase
    end else if (runOp && tckIf.fall && opSel != brto_pkg::OP_SIG) begin
      shadow_next = (ioCells_reg & outMask) | (shadow_reg & ~outMask);
    end
    pinOut_next   = shadow_next;
    pinOe_next    = instrS ? outMask : '0;
    opActive_next = runOp;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioCells_reg   <= brto_pkg::IO_RESET;
      ctrlCells_reg <= brto_pkg::CTRL_RESET;
      shadow_reg    <= brto_pkg::SHADOW_RESET;
      pinOut_reg    <= brto_pkg::SHADOW_RESET;
      pinOe_reg     <= '0;
      opActive_reg  <= 1'b0;
    end else begin
      ioCells_reg   <= ioCells_next;
      ctrlCells_reg <= ctrlCells_next;
      shadow_reg    <= shadow_next;
      pinOut_reg    <= pinOut_next;
      pinOe_reg     <= pinOe_next;
      opActive_reg  <= opActive_next;
    end
  end

  assign ioCells   = ioCells_reg;
  assign ctrlCells = ctrlCells_reg;
  assign pinOut    = pinOut_reg;
  assign pinOe     = pinOe_reg;
  assign opActive  = opActive_reg;

  // ==========================================================================
  // checks
  a_decode_opcode: assert property (
    @(posedge clk) disable iff (rst)
    (bcrS[1:0] == 2'h0 |-> opSel == brto_pkg::OP_TOGGLE) and
    (bcrS == 3'h3 |-> opSel == brto_pkg::OP_SIG_RANDOM) and
    (bcrS == 3'h7 |-> opSel == brto_pkg::OP_SIG_COUNT))
    else $error("opcode decoded to wrong operation");

  a_idle_frozen: assert property (
    @(posedge clk) disable iff (rst)
    (!(instrS && idleS) && !scanLoad) |=> $stable(ioCells_reg) && $stable(shadow_reg))
    else $error("cells changed outside run-test idle");

  a_freeze_exit: assert property (
    @(posedge clk) disable iff (rst)
    ($fell(idleS) && !scanLoad) ##1 !scanLoad [*2] |-> $stable(ioCells_reg))
    else $error("cells not frozen after leaving idle");

  a_ctrl_untouched: assert property (
    @(posedge clk) disable iff (rst)
    !scanLoad |=> ctrlCells_reg == $past(ctrlCells_reg))
    else $error("control cells altered by an operation");

  a_oe_follows: assert property (
    @(posedge clk) disable iff (rst)
    (instrS && !scanLoad && !ctrlCells_reg[brto_pkg::OE_A_IDX])
      |=> pinOe_reg[HW-1:0] == {HW{1'b1}})
    else $error("enable cell low did not drive A pins");

  a_bypass_dir: assert property (
    @(posedge clk) disable iff (rst)
    (oeAbS == oeBaS && !scanLoad) |=> $stable(ioCells_reg) && !opActive_reg)
    else $error("operation ran with both flows equal");

  a_toggle_inverts: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_TOGGLE)
      |=> (ioCells_reg & $past(outMask)) == (~$past(ioCells_reg) & $past(outMask)))
    else $error("output cells not inverted on rise");

  a_sample_capture: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_TOGGLE)
      |=> (ioCells_reg & ~$past(outMask)) == ($past(pinS) & ~$past(outMask)))
    else $error("input pins not captured on rise");

  a_zero_seed: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && !scanLoad && opSel == brto_pkg::OP_RANDOM && ioCells_reg == '0)
      |=> ioCells_reg == '0)
    else $error("zero seed produced a pattern");

  a_shadow_latch: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.fall && !scanLoad && opSel == brto_pkg::OP_RANDOM)
      |=> ##1 (pinOut_reg & $past(outMask, 2)) == ($past(ioCells_reg, 2) & $past(outMask, 2)))
    else $error("pattern not driven on falling edge");

  a_sig_hold: assert property (
    @(posedge clk) disable iff (rst)
    (opSel == brto_pkg::OP_SIG) |=> $stable(shadow_reg))
    else $error("shadow latches changed during signature");

  a_count_inc: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_SIG_COUNT && dirAtoB)
      |=> ioCells_reg[IW-1:HW] == $past(ioCells_reg[IW-1:HW]) + 20'h0_0001)
    else $error("count did not advance by one");

  a_random_step: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_RANDOM)
      |=> ioCells_reg == brto_pkg::brtoStep40($past(ioCells_reg), $past(rev)))
    else $error("pattern did not advance on rise");

  a_sig_fold: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_SIG)
      |=> ioCells_reg == (brto_pkg::brtoStep40($past(ioCells_reg), $past(rev))
                          ^ ($past(pinS) & ~$past(outMask))))
    else $error("signature not folded on rise");

  a_sig20_fold: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && bcrS[1:0] == 2'h3 && dirAtoB)
      |=> ioCells_reg[HW-1:0] == (brto_pkg::brtoStep20($past(ioCells_reg[HW-1:0]), 1'b0)
                                  ^ $past(pinS[HW-1:0])))
    else $error("twenty-bit signature not folded");

  a_pattern20_step: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_SIG_RANDOM && dirAtoB)
      |=> ioCells_reg[IW-1:HW] == brto_pkg::brtoStep20($past(ioCells_reg[IW-1:HW]), 1'b0))
    else $error("twenty-bit pattern did not advance");

  a_count_rev: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.rise && !scanLoad && opSel == brto_pkg::OP_SIG_COUNT && !dirAtoB)
      |=> ioCells_reg[HW-1:0] == $past(ioCells_reg[HW-1:0]) + 20'h0_0001)
    else $error("reverse count did not advance by one");

  a_oe_gated: assert property (
    @(posedge clk) disable iff (rst)
    !instrS |=> pinOe_reg == '0)
    else $error("pins driven without run-test instruction");

  a_oe_input: assert property (
    @(posedge clk) disable iff (rst)
    (instrS && ctrlCells_reg[brto_pkg::OE_B_IDX])
      |=> pinOe_reg[IW-1:HW] == '0)
    else $error("enable cell high did not release B pins");

  a_toggle_drive: assert property (
    @(posedge clk) disable iff (rst)
    (runOp && tckIf.fall && !scanLoad && opSel == brto_pkg::OP_TOGGLE)
      |=> (pinOut_reg & $past(outMask)) == ($past(ioCells_reg) & $past(outMask)))
    else $error("toggled cells not driven on fall");

endmodule : brto_run_test

// *** testbench/brto_tester.sv ***
// tester model: test clock bursts and boundary register loads
`timescale 1ns/1ps
module brto_tester (
  // clock
  input  wire logic        clk,
  // test side
  output logic             tck,
  output logic             scanLoad,
  output logic [39:0]      scanIoData,
  output logic [11:0]      scanCtrlData,
  output logic [2:0]       boundaryControlOp
);
  initial begin
    tck = 1'b0;
    scanLoad = 1'b0;
    scanIoData = 40'h0;
    scanCtrlData = 12'h0;
    boundaryControlOp = 3'h0;
  end

  // ==========================================================
  // seed and opcode go in before any run
  task load(input logic [39:0] io, input logic [11:0] ctl, input logic [2:0] op);
    @(negedge clk);
    boundaryControlOp = op;
    scanIoData = io;
    scanCtrlData = ctl;
    scanLoad = 1'b1;
    @(negedge clk);
    scanLoad = 1'b0;
    scanIoData = ~io;
    scanCtrlData = ~ctl;
  endtask : load

  // ==========================================================
  // clock stands low between bursts, 160 ns period
  task burst(input int n);
    repeat (n) begin
      @(negedge clk);
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
      repeat (7) @(negedge clk);
    end
  endtask : burst
endmodule : brto_tester

// *** testbench/tb.sv ***
// self-checking bench of the boundary run-test operations
`timescale 1ns/1ps
module tb;
  localparam logic [39:0] SEED = 40'hA5C396E17B;
  localparam logic [39:0] PINS = 40'h5A0FF3C6D2;
  localparam logic [39:0] HI   = 40'hFFFFF00000;
  localparam logic [39:0] LO   = 40'h00000FFFFF;
  logic        clk, rst, tck, tapIdle, runTestInstr, oeAtoBn, oeBtoAn, scanLoad, opActive;
  logic [2:0]  boundaryControlOp;
  logic [39:0] pinIn, pinOut, pinOe, scanIoData, ioCells, e, a, b, pv;
  logic [11:0] scanCtrlData, ctrlCells;
  int          failCount, compares;

  brto_run_test u_brto_run_test (.clk(clk), .rst(rst), .tck(tck), .tapIdle(tapIdle),
    .runTestInstr(runTestInstr), .boundaryControlOp(boundaryControlOp),
    .oeAtoBn(oeAtoBn), .oeBtoAn(oeBtoAn), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .scanLoad(scanLoad), .scanIoData(scanIoData),
    .scanCtrlData(scanCtrlData), .ioCells(ioCells), .ctrlCells(ctrlCells),
    .opActive(opActive));
  brto_tester u_brto_tester (.clk(clk), .tck(tck), .scanLoad(scanLoad),
    .scanIoData(scanIoData), .scanCtrlData(scanCtrlData),
    .boundaryControlOp(boundaryControlOp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // reference step, bit-reversed for the other flow
  function automatic logic [39:0] nx(input logic [39:0] v, input int w, input logic rev);
    logic [39:0] t;
    logic        f;
    t = v;
    for (int i = 0; i < w; i++) t[i] = rev ? v[w-1-i] : v[i];
    f = (w == 40) ? t[39] ^ t[37] ^ t[20] ^ t[18] : t[19] ^ t[16];
    t = {t[38:0], f} & ((w == 40) ? 40'hFFFFFFFFFF : LO);
    v = t;
    for (int i = 0; i < w; i++) t[i] = rev ? v[w-1-i] : v[i];
    return t;
  endfunction : nx

  task finalReport;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finalReport

  task automatic chk(input string n, input logic [39:0] x, input logic [39:0] g);
    compares++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      failCount++;
    end
  endtask : chk

  task automatic waitAct;
    int k;
    k = 0;
    while (opActive !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (opActive !== 1'b1) begin
      $display("[ERR] opActive expected 1 seen 0");
      failCount++;
      finalReport();
    end
  endtask : waitAct

  task automatic run(input logic [2:0] op, input logic [39:0] s, input logic [11:0] c,
                     input int n, input logic go);
    tapIdle = 1'b0;
    u_brto_tester.load(s, c, op);
    repeat (4) @(negedge clk);
    tapIdle = go;
    if (go && oeAtoBn != oeBtoAn && runTestInstr) waitAct();
    else begin
      repeat (4) @(negedge clk);
      chk("opActive", 40'h0, {39'h0, opActive});
    end
    u_brto_tester.burst(n);
    tapIdle = 1'b0;
    repeat (4) @(negedge clk);
  endtask : run

  // ==========================================================
  // scenarios
  task scToggle;
    for (int i = 0; i < 2; i++) begin
      run({i[0], 2'h0}, SEED, 12'h800, 3, 1'b1);
      chk("cells", {~SEED[39:20], PINS[19:0]}, ioCells);
      chk("pinOut", {~SEED[39:20], 20'h0}, pinOut & HI);
      chk("pinOe", HI, pinOe);
      chk("ctrl", 40'h800, {28'h0, ctrlCells});
    end
  endtask : scToggle

  task scRandom;
    e = nx(nx(nx(SEED, 40, 1'b0), 40, 1'b0), 40, 1'b0);
    for (int i = 0; i < 2; i++) begin
      run({i[0], 2'h1}, SEED, 12'h800, 3, 1'b1);
      chk("cells", e, ioCells);
      chk("pinOut", e & HI, pinOut & HI);
    end
    run(3'h5, 40'h0, 12'h800, 3, 1'b1);
    chk("zero", 40'h0, ioCells);
  endtask : scRandom

  task scSig;
    pv = pinOut;
    e = nx(nx(SEED, 40, 1'b0) ^ (PINS & LO), 40, 1'b0) ^ (PINS & LO);
    for (int i = 0; i < 2; i++) begin
      run({i[0], 2'h2}, SEED, 12'h800, 2, 1'b1);
      chk("sig", e, ioCells);
      chk("pinOut", pv, pinOut);
    end
  endtask : scSig

  task sc20(input logic [2:0] op, input logic r);
    oeAtoBn = r;
    oeBtoAn = ~r;
    a = r ? {20'h0, SEED[39:20]} : SEED & LO;
    b = r ? SEED & LO : {20'h0, SEED[39:20]};
    pv = r ? {20'h0, PINS[39:20]} : PINS & LO;
    repeat (3) begin
      a = nx(a, 20, r) ^ pv;
      b = op[2] ? ((b + 40'h1) & LO) : nx(b, 20, r);
    end
    e = r ? {a[19:0], b[19:0]} : {b[19:0], a[19:0]};
    run(op, SEED, r ? 12'h400 : 12'h800, 3, 1'b1);
    chk("cells", e, ioCells);
    chk("pinOut", r ? b & LO : {b[19:0], 20'h0}, pinOut & (r ? LO : HI));
    chk("pinOe", r ? LO : HI, pinOe);
  endtask : sc20

  task scRefuse;
    oeBtoAn = 1'b0;
    run(3'h4, SEED, 12'h800, 2, 1'b1);
    chk("bypass", SEED, ioCells);
    oeBtoAn = 1'b1;
    run(3'h4, SEED, 12'h800, 2, 1'b0);
    chk("frozen", SEED, ioCells);
    runTestInstr = 1'b0;
    run(3'h4, SEED, 12'h800, 2, 1'b1);
    chk("noInstr", SEED, ioCells);
    chk("pinOe", 40'h0, pinOe);
    runTestInstr = 1'b1;
  endtask : scRefuse

  task scReverse;
    oeAtoBn = 1'b1;
    oeBtoAn = 1'b0;
    e = nx(nx(SEED, 40, 1'b1), 40, 1'b1);
    run(3'h1, SEED, 12'h400, 2, 1'b1);
    chk("cells", e, ioCells);
    chk("pinOe", LO, pinOe);
    chk("pinOut", e & LO, pinOut & LO);
  endtask : scReverse

  initial begin
    rst = 1'b1;
    tapIdle = 1'b0;
    runTestInstr = 1'b1;
    oeAtoBn = 1'b0;
    oeBtoAn = 1'b1;
    pinIn = PINS;
    failCount = 0;
    compares = 0;
    repeat (6) @(negedge clk);
    chk("rstCells", 40'h0, ioCells);
    chk("rstCtrl", 40'hFFF, {28'h0, ctrlCells});
    chk("rstOut", 40'h0, pinOut ^ pinOe);
    chk("rstAct", 40'h0, {39'h0, opActive});
    rst = 1'b0;
    scToggle();
    scRandom();
    scSig();
    sc20(3'h3, 1'b0);
    sc20(3'h7, 1'b0);
    scRefuse();
    sc20(3'h3, 1'b1);
    sc20(3'h7, 1'b1);
    scReverse();
    finalReport();
  end
endmodule : tb
